/* verilog/alarm_status_aggregator.sv */
// sticky fault flags, suppress mask and summary alarm
// What this block does
// - Summary bit 0 reads 1 exactly when some flag is set and unmasked.
// - Bits 7..1 of the summary register are read-only and read as zero.
// - When selected, the summary alarm is driven onto the status pin.
// - The lock-loss flag (bit 4) is set while the loop is not locked.
// - Writing 1 to a flag bit clears it unless its cause is still live in that cycle; writing 0 leaves it alone.
// - Link-down flag (bit 3) sets when link enabled but not in data state.
// - Realign flag (bit 2) sets when the alignment pulse realigns clocks.
// - Oscillator flag (bit 1) sets when link disabled or oscillators sync.
// - Oscillator flag also sets when any channel A/B accumulator differs.
// - Divider flag (bit 0) sets when channel A and B dividers differ.
// - Mask bits 4..0 map to the flags; a set mask bit hides its flag.
// - After reset the flag register holds 0x1f.
// - After reset the mask register holds 0x1f.
module alarm_status_aggregator
   import alarm_status_pkg::*;
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   // register port
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [DATA_W-1:0] o_rdata,
   // fault sources
   input wire logic i_pll_locked,
   input wire logic i_link_enable,
   input wire logic i_data_encoding_state,
   input wire logic i_sysref_realign,
   input wire logic i_osc_sync,
   input wire logic i_phase_mismatch,
   input wire logic i_divider_mismatch,
   // status pin routing
   input wire logic i_status_sel_alarm,
   input wire logic i_cal_status,
   output logic o_status_output_pin,
   // interrupt
   output logic o_irq
);

   logic [FLAG_W-1:0] fault_flags;
   logic [FLAG_W-1:0] next_fault_flags;
   logic [FLAG_W-1:0] fault_suppress;
   logic [FLAG_W-1:0] next_fault_suppress;
   logic [FLAG_W-1:0] flag_set;
   logic [FLAG_W-1:0] flag_clr;
   logic [DATA_W-1:0] next_rdata;
   logic [2:0] lock_sync;
   logic lock_stable;
   logic next_lock_stable;
   logic summary;
   logic next_irq;
   logic next_status_pin;
   logic first_cyc;

   // lock comes from the analog loop, so it is resynchronised
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         lock_sync <= LOCK_SYNC_RST;
         lock_stable <= 1'b0;
      end
      else
      begin
         lock_sync <= {lock_sync[1:0], i_pll_locked};
         lock_stable <= next_lock_stable;
      end
   end

   // accept a change only once stages two and three agree
   always_comb
   begin
      next_lock_stable = lock_stable;
      if (lock_sync[1] == lock_sync[2])
      begin
         next_lock_stable = lock_sync[2];
      end
   end

   // set conditions are levels sampled every cycle
   always_comb
   begin
      flag_set = '0;
      flag_set[BIT_LOCK_LOSS] = !lock_stable;
      flag_set[BIT_LINK_DOWN] =
         i_link_enable && !i_data_encoding_state;
      flag_set[BIT_CLOCK_REALIGN] = i_sysref_realign;
      flag_set[BIT_OSC_PHASE] = !i_link_enable || i_osc_sync
         || i_phase_mismatch;
      flag_set[BIT_DIV_MISMATCH] = i_divider_mismatch;
   end

   always_comb
   begin
      flag_clr = '0;
      if (i_wr && i_addr == OFF_FAULT_FLAGS)
      begin
         flag_clr = i_wdata[FLAG_W-1:0];
      end
      // set ORed in last so a live fault survives the clear
      next_fault_flags = (fault_flags & ~flag_clr) | flag_set;
   end

   always_comb
   begin
      next_fault_suppress = fault_suppress;
      if (i_wr && i_addr == OFF_FAULT_SUPPRESS)
      begin
         next_fault_suppress = i_wdata[FLAG_W-1:0];
      end
   end

   assign summary = |(fault_flags & ~fault_suppress);

   // read mux; reserved bits and unmapped offsets read as zero
   always_comb
   begin
      next_rdata = '0;
      if (i_rd)
      begin
         case (i_addr)
            OFF_ALARM_SUMMARY:
               next_rdata[BIT_SUMMARY] = summary;
            OFF_FAULT_FLAGS:
               next_rdata[FLAG_W-1:0] = fault_flags;
            OFF_FAULT_SUPPRESS:
               next_rdata[FLAG_W-1:0] = fault_suppress;
            default:
               next_rdata = '0;
         endcase
      end
   end

   always_comb
   begin
      next_irq = summary;
      next_status_pin = i_status_sel_alarm ? summary : i_cal_status;
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         fault_flags <= FAULT_FLAGS_RST;
         fault_suppress <= FAULT_SUPPRESS_RST;
         o_rdata <= RDATA_RST;
         o_irq <= 1'b0;
         o_status_output_pin <= 1'b0;
         first_cyc <= 1'b1;
      end
      else
      begin
         fault_flags <= next_fault_flags;
         fault_suppress <= next_fault_suppress;
         o_rdata <= next_rdata;
         o_irq <= next_irq;
         o_status_output_pin <= next_status_pin;
         first_cyc <= 1'b0;
      end
   end

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_reset_n);

   a_summary_read: assert property (
      i_rd && i_addr == OFF_ALARM_SUMMARY |=>
      o_rdata[0] == |($past(fault_flags) & ~$past(fault_suppress)))
      else $error("summary bit disagrees with flags and mask");

   a_reserved_zero: assert property (
      i_rd && i_addr == OFF_ALARM_SUMMARY |=> o_rdata[7:1] == 7'h00)
      else $error("reserved summary bits not zero");

   a_pin_route: assert property (
      1'b1 |=> o_status_output_pin ==
      ($past(i_status_sel_alarm) ? $past(summary) : $past(i_cal_status)))
      else $error("status pin not routed as selected");

   a_lock_flag: assert property (
      !lock_stable |=> fault_flags[BIT_LOCK_LOSS])
      else $error("lock loss not flagged");

   a_clear_one: assert property (
      i_wr && i_addr == OFF_FAULT_FLAGS && flag_set == 5'h00 |=>
      fault_flags == ($past(fault_flags) & ~$past(i_wdata[4:0])))
      else $error("write one to clear misbehaves");

   a_hold_no_write: assert property (
      !(i_wr && i_addr == OFF_FAULT_FLAGS) |=>
      fault_flags == ($past(fault_flags) | $past(flag_set)))
      else $error("flags changed without a clearing write");

   a_link_flag: assert property (
      i_link_enable && !i_data_encoding_state |=> fault_flags[3])
      else $error("link down not flagged");

   a_realign_flag: assert property (
      i_sysref_realign |=> fault_flags[2])
      else $error("realignment not flagged");

   a_osc_flag: assert property (
      !i_link_enable || i_osc_sync |=> fault_flags[1])
      else $error("oscillator disable or sync not flagged");

   a_phase_flag: assert property (
      i_phase_mismatch |=> fault_flags[1])
      else $error("accumulator mismatch not flagged");

   a_div_flag: assert property (
      i_divider_mismatch |=> fault_flags[0])
      else $error("divider mismatch not flagged");

   a_mask_gate: assert property (
      ##1 o_irq == |($past(fault_flags) & ~$past(fault_suppress)))
      else $error("interrupt not gated by mask");

   a_reset_flags: assert property (
      first_cyc |-> fault_flags == FAULT_FLAGS_RST)
      else $error("flags wrong after reset");

   a_reset_mask: assert property (
      first_cyc |-> fault_suppress == FAULT_SUPPRESS_RST)
      else $error("mask wrong after reset");

   a_set_wins: assert property (
      i_wr && i_addr == OFF_FAULT_FLAGS && i_wdata[0]
      && i_divider_mismatch |=> fault_flags[0])
      else $error("clear beat a live fault");

   a_pin_alarm: assert property (
      i_status_sel_alarm |=> o_status_output_pin == $past(summary))
      else $error("summary alarm missing on status pin");

   a_pin_pass: assert property (
      !i_status_sel_alarm |=> o_status_output_pin == $past(i_cal_status))
      else $error("calibration status not passed to pin");

   a_irq_low: assert property (
      (fault_flags & ~fault_suppress) == 5'h00 |=> !o_irq)
      else $error("interrupt high with no unmasked flag");

   a_irq_high: assert property (
      (fault_flags & ~fault_suppress) != 5'h00 |=> o_irq)
      else $error("interrupt low with an unmasked flag");

   a_mask_all: assert property (
      fault_suppress == 5'h1f |=> !o_irq)
      else $error("fully masked flags raised the interrupt");

   a_mask_write: assert property (
      i_wr && i_addr == OFF_FAULT_SUPPRESS |=>
      fault_suppress == $past(i_wdata[4:0]))
      else $error("mask write not taken");

   a_mask_hold: assert property (
      !(i_wr && i_addr == OFF_FAULT_SUPPRESS) |=> $stable(fault_suppress))
      else $error("mask changed without a write");

   a_flags_read: assert property (
      i_rd && i_addr == OFF_FAULT_FLAGS |=>
      o_rdata == {3'h0, $past(fault_flags)})
      else $error("flag register read wrong");

   a_mask_read: assert property (
      i_rd && i_addr == OFF_FAULT_SUPPRESS |=>
      o_rdata == {3'h0, $past(fault_suppress)})
      else $error("mask register read wrong");

   a_idle_rdata: assert property (
      !i_rd |=> o_rdata == 8'h00)
      else $error("read data not zero outside a read");

   a_unmapped_read: assert property (
      i_rd && i_addr != OFF_ALARM_SUMMARY && i_addr != OFF_FAULT_FLAGS
      && i_addr != OFF_FAULT_SUPPRESS |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");

   a_lock_filter: assert property (
      !lock_sync[2] && !lock_sync[1] |=> !lock_stable)
      else $error("lock loss not passed by the filter");

   a_lock_wins: assert property (
      i_wr && i_addr == OFF_FAULT_FLAGS && i_wdata[4] && !lock_stable
      |=> fault_flags[BIT_LOCK_LOSS])
      else $error("clear beat a live lock loss");

   a_link_wins: assert property (
      i_wr && i_addr == OFF_FAULT_FLAGS && i_wdata[3] && i_link_enable
      && !i_data_encoding_state |=> fault_flags[BIT_LINK_DOWN])
      else $error("clear beat a live link fault");

   a_realign_wins: assert property (
      i_wr && i_addr == OFF_FAULT_FLAGS && i_wdata[2] && i_sysref_realign
      |=> fault_flags[BIT_CLOCK_REALIGN])
      else $error("clear beat a live realignment");

   a_osc_wins: assert property (
      i_wr && i_addr == OFF_FAULT_FLAGS && i_wdata[1]
      && (!i_link_enable || i_osc_sync || i_phase_mismatch)
      |=> fault_flags[BIT_OSC_PHASE])
      else $error("clear beat a live oscillator fault");

   a_clear_drops: assert property (
      i_wr && i_addr == OFF_FAULT_FLAGS |=>
      (fault_flags & $past(i_wdata[4:0]) & ~$past(flag_set)) == 5'h00)
      else $error("written one left an idle flag set");

endmodule

/* verilog/alarm_status_pkg.sv */
// constants of the alarm status aggregator
package alarm_status_pkg;
   // register port
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int FLAG_W = 5;

   // register offsets
   localparam logic [11:0] OFF_ALARM_SUMMARY = 12'h2c0;
   localparam logic [11:0] OFF_FAULT_FLAGS = 12'h2c1;
   localparam logic [11:0] OFF_FAULT_SUPPRESS = 12'h2c2;

   // field positions; BIT_SUMMARY is in the summary register, the rest are shared by flags and suppress
   localparam int BIT_SUMMARY = 0;
   localparam int BIT_LOCK_LOSS = 4;
   localparam int BIT_LINK_DOWN = 3;
   localparam int BIT_CLOCK_REALIGN = 2;
   localparam int BIT_OSC_PHASE = 1;
   localparam int BIT_DIV_MISMATCH = 0;

   // values after reset
   localparam logic [4:0] FAULT_FLAGS_RST = 5'h1f;
   localparam logic [4:0] FAULT_SUPPRESS_RST = 5'h1f;
   localparam logic [7:0] RDATA_RST = 8'h00;
   localparam logic [2:0] LOCK_SYNC_RST = 3'h0;
endpackage

/* testbench/tb.sv */
// register-level bench for the alarm status aggregator
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import alarm_status_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_reset_n = 1'b0;
   logic [11:0] i_addr = 12'h000;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [7:0] o_rdata;
   logic [6:0] src = 7'h00;
   logic i_status_sel_alarm = 1'b0;
   logic i_cal_status = 1'b0;
   logic o_status_output_pin;
   logic o_irq;
   int bad_count = 0;
   int n_checks = 0;
   // src: {link off, phase, lock loss, link down, realign, osc sync, div}
   logic [6:0] rows [7] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40};
   logic [7:0] want [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h02, 8'h02};
   alarm_status_aggregator i_dut (
      .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_pll_locked(~src[4]), .i_link_enable(~src[6]),
      .i_data_encoding_state(~src[3]), .i_sysref_realign(src[2]),
      .i_osc_sync(src[1]), .i_phase_mismatch(src[5]),
      .i_divider_mismatch(src[0]), .i_status_sel_alarm(i_status_sel_alarm),
      .i_cal_status(i_cal_status), .o_status_output_pin(o_status_output_pin),
      .o_irq(o_irq));
   initial
   begin
      forever #4 i_clk_sys = ~i_clk_sys;
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge i_clk_sys) i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys) i_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
      @(posedge i_clk_sys) i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys) i_rd <= 1'b0;
      #1 check(o_rdata, exp);
   endtask
   task automatic pulse(input logic [6:0] v);
      @(posedge i_clk_sys) src <= v;
      repeat (6) @(posedge i_clk_sys);
      src <= 7'h00;
      repeat (6) @(posedge i_clk_sys);
   endtask
   task automatic finish_test();
      if (bad_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      #50000;
      bad_count++;
      finish_test();
   end
   initial
   begin
      repeat (4) @(posedge i_clk_sys);
      i_reset_n <= 1'b1;
      rdc(OFF_FAULT_FLAGS, 8'h1f);
      rdc(OFF_FAULT_SUPPRESS, 8'h1f);
      rdc(OFF_ALARM_SUMMARY, 8'h00);
      repeat (8) @(posedge i_clk_sys);
      wr(OFF_FAULT_FLAGS, 8'hff);
      rdc(OFF_FAULT_FLAGS, 8'h00);
      for (int i = 0; i < 7; i++)
      begin
         pulse(rows[i]);
         rdc(OFF_FAULT_FLAGS, want[i]);
         wr(OFF_FAULT_FLAGS, 8'h00);
         rdc(OFF_FAULT_FLAGS, want[i]);
         wr(OFF_FAULT_FLAGS, want[i]);
         rdc(OFF_FAULT_FLAGS, 8'h00);
      end
      // unmask only the divider flag first
      pulse(7'h01);
      wr(OFF_FAULT_SUPPRESS, 8'h1e);
      rdc(OFF_FAULT_SUPPRESS, 8'h1e);
      rdc(OFF_ALARM_SUMMARY, 8'h01);
      wr(OFF_FAULT_SUPPRESS, 8'h01);
      rdc(OFF_ALARM_SUMMARY, 8'h00);
      wr(OFF_FAULT_SUPPRESS, 8'h1e);
      wr(OFF_ALARM_SUMMARY, 8'hff);
      rdc(OFF_ALARM_SUMMARY, 8'h01);
      check({7'h00, o_irq}, 8'h01);
      rdc(12'h2c3, 8'h00);
      @(posedge i_clk_sys) i_status_sel_alarm <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      #1 check({7'h00, o_status_output_pin}, 8'h01);
      wr(OFF_FAULT_FLAGS, 8'h01);
      repeat (2) @(posedge i_clk_sys);
      #1 check({6'h00, o_irq, o_status_output_pin}, 8'h00);
      @(posedge i_clk_sys) i_status_sel_alarm <= 1'b0;
      i_cal_status <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      #1 check({7'h00, o_status_output_pin}, 8'h01);
      // clear arriving while the cause is still present
      // every cause live except link off, lock loss given time through its filter
      @(posedge i_clk_sys) src <= 7'h3f;
      repeat (4) @(posedge i_clk_sys);
      wr(OFF_FAULT_FLAGS, 8'h1f);
      rdc(OFF_FAULT_FLAGS, 8'h1f);
      wr(OFF_FAULT_SUPPRESS, 8'hff);
      rdc(OFF_FAULT_SUPPRESS, 8'h1f);
      rdc(OFF_ALARM_SUMMARY, 8'h00);
      // reset again in mid-run after the mask was changed
      wr(OFF_FAULT_SUPPRESS, 8'h00);
      @(posedge i_clk_sys) i_reset_n <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
      i_reset_n <= 1'b1;
      rdc(OFF_FAULT_SUPPRESS, 8'h1f);
      rdc(OFF_FAULT_FLAGS, 8'h1f);
      check({7'h00, o_irq}, 8'h00);
      finish_test();
   end
endmodule
